// file: hw/adc_frame_pkg.sv
package adc_frame_pkg;
  localparam int CODE_W    = 16;
  localparam int HYS_W     = 8;
  localparam int CMD_W     = 16;
  localparam int EDGE_W    = 6;
  localparam int FIRST_OUT = 16;
  localparam int CHF_W     = 4;
  localparam int OUT_W     = CODE_W + CHF_W;
  // command word layout: opcode in top nibble, channel below it
  localparam int OP_MSB    = 15;
  localparam int OP_LSB    = 12;
  localparam int CH_MSB    = 11;
  localparam int CH_LSB    = 8;
  localparam logic [3:0] OP_AUTO = 4'ha;
  localparam logic [3:0] OP_MAN  = 4'hc;
  // conversion time of the internal oscillator path
  localparam int CLK_NS    = 50;
  localparam int CONV_NS   = 1000;
  localparam int CONV_CYC  = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CW   = 6;

  typedef enum logic {
    FMT_DATA    = 1'b0,
    FMT_DATA_CH = 1'b1
  } out_fmt_t;

  typedef enum logic {
    F_IDLE = 1'b0,
    F_ACT  = 1'b1
  } frame_t;
endpackage

// file: hw/adc_serial_frame_alarm.sv
`timescale 1ns/1ps
module adc_serial_frame_alarm #(
  parameter int NCH  = 8,
  parameter int CH_W = 3
) (
  // clock and reset
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst_n,
  // serial link pins
  input  wire logic                                    cs_n,
  input  wire logic                                    sclk,
  input  wire logic                                    sdi,
  output logic                                         sdo,
  output logic                                         sdo_oe,
  output logic                                         alarm,
  // configuration
  input  wire logic [NCH-1:0]                          scan_en,
  input  wire logic                                    fmt_sel,
  input  wire logic [NCH*adc_frame_pkg::CODE_W-1:0]    hi_thr,
  input  wire logic [NCH*adc_frame_pkg::HYS_W-1:0]     hi_hys,
  input  wire logic [NCH*adc_frame_pkg::CODE_W-1:0]    lo_thr,
  input  wire logic [NCH*adc_frame_pkg::HYS_W-1:0]     lo_hys,
  // alarm flags and read strobes
  input  wire logic [NCH-1:0]                          trip_hi_rd,
  input  wire logic [NCH-1:0]                          trip_lo_rd,
  output logic      [NCH-1:0]                          act_hi,
  output logic      [NCH-1:0]                          act_lo,
  output logic      [NCH-1:0]                          trip_hi,
  output logic      [NCH-1:0]                          trip_lo,
  // converter core
  output logic      [CH_W-1:0]                         ain_sel,
  output logic                                         sample_stb,
  input  wire logic [adc_frame_pkg::CODE_W-1:0]        conv_code,
  output logic                                         auto_mode
);

  localparam int CW = adc_frame_pkg::CODE_W;
  localparam int HW = adc_frame_pkg::HYS_W;
  localparam int OW = adc_frame_pkg::OUT_W;
  localparam int EW = adc_frame_pkg::EDGE_W;
  localparam int QW = adc_frame_pkg::CONV_CW;
  localparam int CONV_LIM = adc_frame_pkg::CONV_CYC + 1;

  // next enabled channel above cur, wrapping, or lowest enabled channel if from_low; cur if none enabled
  function automatic logic [CH_W-1:0] next_ch(input logic [CH_W-1:0] cur,
                                              input logic [NCH-1:0]  en,
                                              input logic            from_low);
    logic [CH_W-1:0] c;
    logic            hit;
    c   = cur;
    hit = 1'b0;
    for (int k = NCH; k >= 1; k--) begin
      if (en[CH_W'((from_low ? 0 : int'(cur)) + (from_low ? k - 1 : k)) ]) begin
        c   = CH_W'((from_low ? 0 : int'(cur)) + (from_low ? k - 1 : k));
        hit = 1'b1;
      end
    end
    return hit ? c : cur;
  endfunction

  // pin synchronisers plus one edge stage
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sk_s1_q, sk_s2_q, sk_s3_q;
  logic di_s1_q, di_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
      {sk_s1_q, sk_s2_q, sk_s3_q} <= 3'h7;
      {di_s1_q, di_s2_q}          <= 2'h0;
    end else begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {cs_n, cs_s1_q, cs_s2_q};
      {sk_s1_q, sk_s2_q, sk_s3_q} <= {sclk, sk_s1_q, sk_s2_q};
      {di_s1_q, di_s2_q}          <= {sdi, di_s1_q};
    end
  end

  logic cs_fall, cs_rise, sk_fall, edge16;
  assign cs_fall = cs_s3_q & ~cs_s2_q;
  assign cs_rise = ~cs_s3_q & cs_s2_q;

  adc_frame_pkg::frame_t frame_q, frame_d;
  logic [EW-1:0]   edge_q, edge_d;
  logic [CW-1:0]   sdi_sr_q, sdi_sr_d, pend_q, pend_d;
  logic            pend_vld_q, pend_vld_d;
  logic            auto_q, auto_d;
  logic [CH_W-1:0] ch_q, ch_d;
  logic            fmt_q, fmt_d;
  logic [OW-1:0]   out_sr_q, out_sr_d, load_w;
  logic            sdo_q, sdo_d, oe_q, oe_d;
  logic [QW-1:0]   conv_cnt_q, conv_cnt_d;
  logic            busy_q, busy_d;
  logic [CW-1:0]   result_q, result_d;
  logic [CH_W-1:0] res_ch_q, res_ch_d;
  logic            res_new_q, res_new_d;
  logic            smp_q, smp_d;
  logic            alarm_q, alarm_d;

  // sdi capture and sdo shifting keyed to sclk falling edges
  assign sk_fall = sk_s3_q & ~sk_s2_q & (frame_q == adc_frame_pkg::F_ACT) & ~cs_s2_q;
  assign edge16  = sk_fall & (edge_q == EW'(adc_frame_pkg::FIRST_OUT - 1));

  always_comb begin
    frame_d    = frame_q;
    edge_d     = edge_q;
    sdi_sr_d   = sdi_sr_q;
    pend_d     = pend_q;
    pend_vld_d = pend_vld_q;
    auto_d     = auto_q;
    ch_d       = ch_q;
    fmt_d      = fmt_q;
    out_sr_d   = out_sr_q;
    sdo_d      = sdo_q;
    oe_d       = oe_q;
    conv_cnt_d = conv_cnt_q;
    busy_d     = busy_q;
    result_d   = result_q;
    res_ch_d   = res_ch_q;
    res_new_d  = 1'b0;
    smp_d      = 1'b0;
    alarm_d    = alarm_q;
    // channel field appended only in the FMT_DATA_CH format, zeros in its place otherwise
    load_w = (fmt_q == adc_frame_pkg::FMT_DATA_CH) ?
             {result_q, adc_frame_pkg::CHF_W'(res_ch_q)} :
             {result_q, {adc_frame_pkg::CHF_W{1'b0}}};
    // latch straight-binary code when conversion ends
    if (busy_q) begin
      conv_cnt_d = conv_cnt_q - QW'(1);
      if (conv_cnt_q == QW'(1)) begin
        busy_d    = 1'b0;
        result_d  = conv_code;
        res_ch_d  = ch_q;
        res_new_d = 1'b1;
      end
    end
    if (cs_fall) begin
      // apply last frame's command, then sample
      frame_d = adc_frame_pkg::F_ACT;
      edge_d  = '0;
      fmt_d   = fmt_sel;
      if (pend_vld_q && pend_q[adc_frame_pkg::OP_MSB:adc_frame_pkg::OP_LSB] ==
          adc_frame_pkg::OP_MAN) begin
        auto_d = 1'b0;
        ch_d   = CH_W'(pend_q[adc_frame_pkg::CH_MSB:adc_frame_pkg::CH_LSB]);
      end else if (pend_vld_q &&
                   pend_q[adc_frame_pkg::OP_MSB:adc_frame_pkg::OP_LSB] ==
                   adc_frame_pkg::OP_AUTO) begin
        auto_d = 1'b1;
        ch_d   = next_ch(ch_q, scan_en, 1'b1);
      end else if (auto_q) begin
        // ascending step to next enabled channel
        ch_d = next_ch(ch_q, scan_en, 1'b0);
      end
      pend_vld_d = 1'b0;
      smp_d      = 1'b1;
      busy_d     = 1'b1;
      conv_cnt_d = QW'(adc_frame_pkg::CONV_CYC);
      // release output and hold it low
      oe_d  = 1'b1;
      sdo_d = 1'b0;
    end else if (cs_rise) begin
      frame_d = adc_frame_pkg::F_IDLE;
      oe_d    = 1'b0;
      sdo_d   = 1'b0;
    end else if (sk_fall) begin
      if (edge_q != {EW{1'b1}}) begin
        edge_d = edge_q + EW'(1);
      end
      if (edge_q < EW'(adc_frame_pkg::FIRST_OUT)) begin
        sdi_sr_d = {sdi_sr_q[CW-2:0], di_s2_q};
      end
      if (edge16) begin
        pend_d     = {sdi_sr_q[CW-2:0], di_s2_q};
        pend_vld_d = 1'b1;
        sdo_d    = load_w[OW-1];
        out_sr_d = {load_w[OW-2:0], 1'b0};
        alarm_d = (|trip_hi) | (|trip_lo);
      end else if (edge_q >= EW'(adc_frame_pkg::FIRST_OUT)) begin
        // shift out, zeros fill after the last bit
        sdo_d    = out_sr_q[OW-1];
        out_sr_d = {out_sr_q[OW-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q    <= adc_frame_pkg::F_IDLE;
      edge_q     <= '0;
      sdi_sr_q   <= '0;
      pend_q     <= '0;
      pend_vld_q <= 1'b0;
      auto_q     <= 1'b0;
      ch_q       <= '0;
      fmt_q      <= 1'b0;
      out_sr_q   <= '0;
      sdo_q      <= 1'b0;
      oe_q       <= 1'b0;
      conv_cnt_q <= '0;
      busy_q     <= 1'b0;
      result_q   <= '0;
      res_ch_q   <= '0;
      res_new_q  <= 1'b0;
      smp_q      <= 1'b0;
      alarm_q    <= 1'b0;
    end else begin
      frame_q    <= frame_d;
      edge_q     <= edge_d;
      sdi_sr_q   <= sdi_sr_d;
      pend_q     <= pend_d;
      pend_vld_q <= pend_vld_d;
      auto_q     <= auto_d;
      ch_q       <= ch_d;
      fmt_q      <= fmt_d;
      out_sr_q   <= out_sr_d;
      sdo_q      <= sdo_d;
      oe_q       <= oe_d;
      conv_cnt_q <= conv_cnt_d;
      busy_q     <= busy_d;
      result_q   <= result_d;
      res_ch_q   <= res_ch_d;
      res_new_q  <= res_new_d;
      smp_q      <= smp_d;
      alarm_q    <= alarm_d;
    end
  end

  assign sdo        = sdo_q;
  assign sdo_oe     = oe_q;
  assign alarm      = alarm_q;
  assign ain_sel    = ch_q;
  assign sample_stb = smp_q;
  assign auto_mode  = auto_q;

  // per-channel alarm comparators
  logic signed [CW+2:0] code_s;
  assign code_s = $signed({3'b000, result_q});

  for (genvar i = 0; i < NCH; i++) begin : g_alarm
    logic signed [CW+2:0] ht, hh, lt, lh;
    logic set_hi, clr_hi, set_lo, clr_lo, upd;
    logic ah_q, ah_d, al_q, al_d, th_q, th_d, tl_q, tl_d;
    assign ht  = $signed({3'b000, hi_thr[i*CW +: CW]});
    assign hh  = $signed({{(CW+3-HW){1'b0}}, hi_hys[i*HW +: HW]});
    assign lt  = $signed({3'b000, lo_thr[i*CW +: CW]});
    assign lh  = $signed({{(CW+3-HW){1'b0}}, lo_hys[i*HW +: HW]});
    assign upd = res_new_q & (res_ch_q == CH_W'(i));
    assign set_hi = code_s > ht + hh;
    assign clr_hi = code_s <= ht - hh - (CW+3)'(2);
    assign set_lo = code_s < lt - lh - (CW+3)'(1);
    assign clr_lo = code_s >= lt + lh + (CW+3)'(1);

    always_comb begin
      ah_d = ah_q;
      al_d = al_q;
      if (upd && set_hi) ah_d = 1'b1;
      else if (upd && clr_hi) ah_d = 1'b0;
      if (upd && set_lo) al_d = 1'b1;
      else if (upd && clr_lo) al_d = 1'b0;
      // tripped flags latch, set wins over read clear
      th_d = (ah_d & ~ah_q) ? 1'b1 : (trip_hi_rd[i] ? 1'b0 : th_q);
      tl_d = (al_d & ~al_q) ? 1'b1 : (trip_lo_rd[i] ? 1'b0 : tl_q);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        {ah_q, al_q, th_q, tl_q} <= 4'h0;
      end else begin
        {ah_q, al_q, th_q, tl_q} <= {ah_d, al_d, th_d, tl_d};
      end
    end

    assign act_hi[i]  = ah_q;
    assign act_lo[i]  = al_q;
    assign trip_hi[i] = th_q;
    assign trip_lo[i] = tl_q;

    a_high_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      upd && set_hi |=> ah_q && (th_q || $past(ah_q)))
      else $error("high alarm not set above limit");
    a_low_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      upd && clr_lo && !set_lo |=> !al_q)
      else $error("low alarm not cleared at upper limit");
    a_trip_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      th_q && !trip_hi_rd[i] |=> th_q)
      else $error("tripped flag dropped without read");
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_edge16;
    edge16 ##1 1'b1;
  endsequence

  a_sdo_open: assert property (
    cs_fall |=> oe_q && !sdo_q)
    else $error("output not released low at frame start");
  a_sdo_early_low: assert property (
    frame_q == adc_frame_pkg::F_ACT && edge_q < EW'(adc_frame_pkg::FIRST_OUT) |-> !sdo_q)
    else $error("output not low before 16th edge");
  a_msb_out: assert property (
    s_edge16 |-> sdo_q == $past(result_q[CW-1]))
    else $error("msb not driven on 16th edge");
  a_sdo_release: assert property (
    cs_rise |=> !oe_q && !sdo_q)
    else $error("output not released on deselect");
  a_alarm_when: assert property (
    $changed(alarm_q) |-> $past(edge16))
    else $error("alarm changed off the 16th edge");
  a_alarm_or: assert property (
    s_edge16 |-> alarm_q == $past((|trip_hi) | (|trip_lo)))
    else $error("alarm does not reflect tripped flags");
  a_conv_done: assert property (
    cs_fall |-> ##[1:CONV_LIM] res_new_q)
    else $error("conversion did not finish in time");
  a_cfg_apply: assert property (
    $changed(ch_q) |-> $past(cs_fall))
    else $error("channel changed outside select edge");
  a_idle_quiet: assert property (
    cs_s2_q && cs_s3_q |=> !smp_q && !edge16)
    else $error("frame activity while deselected");

endmodule

// file: verification/host_model.sv
`timescale 1ns/1ps
// serial host; sclk idles high between frames
module host_model (
  // clock
  input  wire logic        ref_clk,
  // link pins
  output logic             cs_n,
  output logic             sclk,
  output logic             sdi,
  input  wire logic        sdo_pin,
  input  wire logic        oe_pin,
  // captured frame
  output logic [39:0]      rx,
  output logic             oe_all,
  output logic             done
);
  initial begin
    cs_n   = 1'b1;
    sclk   = 1'b1;
    sdi    = 1'b0;
    rx     = '0;
    oe_all = 1'b0;
    done   = 1'b0;
  end

  // select falls, 16 command bits, 40 slow falls
  task automatic run_frame(input logic [15:0] cmd);
    oe_all = 1'b1;
    @(negedge ref_clk);
    cs_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i < 40; i++) begin
      sdi = (i < 16) ? cmd[15-i] : ~sdi;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
      rx = {rx[38:0], sdo_pin};
      oe_all = oe_all & oe_pin;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
    end
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    @(negedge ref_clk);
    done = 1'b1;
    @(negedge ref_clk);
    done = 1'b0;
  endtask

  // clock pulses with select high, meant to be ignored
  task automatic stray(input int n);
    repeat (2 * n) begin
      repeat (4) @(negedge ref_clk);
      sclk = ~sclk;
      sdi = ~sdi;
    end
  endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic              ref_clk, rst_n, cs_n, sclk, sdi, sdo, sdo_oe, alarm;
  logic              fmt_sel, sample_stb, auto_mode, oe_all, done;
  logic [7:0]        scan_en, trip_hi_rd, trip_lo_rd, act_hi, act_lo, trip_hi, trip_lo;
  logic [127:0]      hi_thr, lo_thr;
  logic [63:0]       hi_hys, lo_hys;
  logic [2:0]        ain_sel, prev, nch;
  logic [15:0]       conv_code;
  logic [39:0]       rx;
  logic [40:0]       exp_q[$];
  logic [2:0]        ch_q[$];
  logic [20:0]       tbl[9];
  wire               sdo_pin;
  int                fails, n_checks;
  integer            seed, rnd;

  assign sdo_pin = sdo_oe ? sdo : 1'bz;

  adc_serial_frame_alarm dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .alarm(alarm), .scan_en(scan_en),
    .fmt_sel(fmt_sel), .hi_thr(hi_thr), .hi_hys(hi_hys), .lo_thr(lo_thr), .lo_hys(lo_hys),
    .trip_hi_rd(trip_hi_rd), .trip_lo_rd(trip_lo_rd), .act_hi(act_hi), .act_lo(act_lo),
    .trip_hi(trip_hi), .trip_lo(trip_lo), .ain_sel(ain_sel), .sample_stb(sample_stb),
    .conv_code(conv_code), .auto_mode(auto_mode));

  host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_pin(sdo_pin),
    .oe_pin(sdo_oe), .rx(rx), .oe_all(oe_all), .done(done));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [40:0] seen, input logic [40:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [15:0] man(input logic [2:0] c);
    return {adc_frame_pkg::OP_MAN, 1'b0, c, 8'h00};
  endfunction

  // one frame: note expected channel and bits, then let the host run it
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] code, input logic [2:0] ch);
    conv_code = code;
    ch_q.push_back(ch);
    exp_q.push_back({16'h0000, code, fmt_sel ? {1'b0, ch, 4'h0} : 8'h00, 1'b1});
    host.run_frame(cmd);
    repeat (6) @(negedge ref_clk);
    check("sdo_oe idle", sdo_oe, 1'b0);
  endtask

  task automatic read_trip(input logic hi);
    @(negedge ref_clk);
    if (hi) trip_hi_rd = 8'h08;
    else trip_lo_rd = 8'h08;
    @(negedge ref_clk);
    trip_hi_rd = 8'h00;
    trip_lo_rd = 8'h00;
    repeat (3) @(negedge ref_clk);
    check("trip cleared", {trip_hi[3], trip_lo[3]}, 2'b00);
    check("alarm held", alarm, 1'b1);
  endtask

  always @(posedge ref_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) check("frame extra", 41'h1, 41'h0);
      else check("frame bits", {rx, oe_all}, exp_q.pop_front());
    end
    if (sample_stb === 1'b1) begin
      if (ch_q.size() == 0) check("stray sample", 41'h1, 41'h0);
      else check("ain_sel", ain_sel, ch_q.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    $display("[ERR] watchdog expected finish seen timeout");
    print_verdict();
  end

  initial begin
    seed = 32'he97c89d9;
    rst_n = 1'b0;
    fmt_sel = 1'b0;
    scan_en = 8'h00;
    trip_hi_rd = 8'h00;
    trip_lo_rd = 8'h00;
    conv_code = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      hi_thr[i*16+:16] = 16'hf000;
      hi_hys[i*8+:8] = 8'h08;
      lo_thr[i*16+:16] = 16'h0010;
      lo_hys[i*8+:8] = 8'h02;
    end
    // separate limits and hysteresis on one channel
    hi_thr[48+:16] = 16'h03e8;
    hi_hys[24+:8] = 8'h05;
    lo_thr[48+:16] = 16'h01f4;
    lo_hys[24+:8] = 8'h04;
    tbl = '{{16'h03ed, 5'b00000}, {16'h03ee, 5'b10101}, {16'h03e2, 5'b10101},
            {16'h03e1, 5'b00101}, {16'h01ef, 5'b00000}, {16'h01ee, 5'b01011},
            {16'h01f8, 5'b01011}, {16'h01f9, 5'b00011}, {16'h02bc, 5'b00000}};
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("reset outs", {sdo_oe, alarm, auto_mode, sample_stb}, 4'h0);
    prev = 3'd0;
    for (int k = 0; k < 8; k++) begin
      rnd = $random(seed);
      nch = rnd[2:0];
      if (nch == 3'd3) nch = 3'd4;
      fmt_sel = k[0];
      xfer(man(nch), {1'b0, rnd[30:16]} | 16'h0100, prev);
      prev = nch;
    end
    $display("test random frames done");
    host.stray(10);
    repeat (6) @(negedge ref_clk);
    check("stray oe", sdo_oe, 1'b0);
    $display("test idle select done");
    fmt_sel = 1'b0;
    xfer(man(3'd3), 16'h02bc, prev);
    for (int k = 0; k < 9; k++) begin
      xfer(man(3'd3), tbl[k][20:5], 3'd3);
      check("act", {act_hi, act_lo}, {4'h0, tbl[k][4], 7'h00, tbl[k][3], 3'h0});
      check("trip", {trip_hi, trip_lo}, {4'h0, tbl[k][2], 7'h00, tbl[k][1], 3'h0});
      check("alarm", alarm, tbl[k][0]);
      if (k == 3) read_trip(1'b1);
      if (k == 7) read_trip(1'b0);
    end
    $display("test alarm limits done");
    scan_en = 8'ha4;
    xfer({adc_frame_pkg::OP_AUTO, 12'h000}, 16'h1000, 3'd3);
    xfer(16'h0000, 16'h1001, 3'd2);
    xfer(16'h0000, 16'h1002, 3'd5);
    xfer(16'h0000, 16'h1003, 3'd7);
    check("auto on", auto_mode, 1'b1);
    xfer(man(3'd6), 16'h1004, 3'd2);
    xfer(man(3'd6), 16'h1005, 3'd6);
    check("auto off", auto_mode, 1'b0);
    $display("test auto scan done");
    print_verdict();
  end
endmodule
